// >>> design/fp_alu_pkg.sv
// Shared constants for the floating-point datapath and its register interface
package fp_alu_pkg;
	localparam int WORD_W = 32;
	localparam int FRAC_W = 23;
	localparam int IEEE_BIAS = 127;
	localparam int DEC_BIAS = 128;
	// Alternate format has mantissa 0.1f, so its internal exponent sits two below biased
	localparam int DEC_EXP_SHIFT = DEC_BIAS - IEEE_BIAS + 1;
	localparam logic [7:0] EXP_ONES = 8'hff;
	localparam logic [11:0] IEEE_EXP_MAX = 12'hfe;
	localparam logic [11:0] DEC_EXP_MAX = 12'h0ff;
	localparam logic [31:0] QNAN_WORD = 32'h7fc00000;
	localparam logic [31:0] RSV_WORD = 32'h80000000;

	localparam logic [2:0] OP_ADD = 3'h0;
	localparam logic [2:0] OP_SUB = 3'h1;

	localparam logic [1:0] RND_NEAREST = 2'h0;
	localparam logic [1:0] RND_PLUS = 2'h1;
	localparam logic [1:0] RND_MINUS = 2'h2;
	localparam logic [1:0] RND_ZERO = 2'h3;

	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] RESULT_OFF = 8'h08;
	localparam logic [31:0] CTRL_RESET = 32'h0001e020;

	localparam int CB_OP = 0;
	localparam int CB_PORTB = 3;
	localparam int CB_ASRC = 4;
	localparam int CB_FMT = 5;
	localparam int CB_INF = 6;
	localparam int CB_RND = 7;
	localparam int CB_IBYP = 9;
	localparam int CB_OBYP = 10;
	localparam int CB_HALF = 11;
	localparam int CB_SHARED = 12;
	localparam int CB_DRIVE_N = 13;
	localparam int CB_LOAD_A_N = 14;
	localparam int CB_LOAD_B_N = 15;
	localparam int CB_LOAD_F_N = 16;
	localparam int CTRL_BITS = 17;

	localparam int FLG_INVALID = 0;
	localparam int FLG_NAN = 1;
	localparam int FLG_OVF = 2;
	localparam int FLG_UNF = 3;
	localparam int FLG_INEXACT = 4;
	localparam int FLG_ZERO = 5;
	localparam int FLG_W = 6;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {PH_LOW, PH_HIGH} half_phase_t;
endpackage : fp_alu_pkg

// >>> design/fp_operand_if.sv
// Unpacked operand fields passed from a decoder to the arithmetic core
`timescale 1ns/100ps
interface fp_operand_if;
	logic        sign;
	logic [9:0]  exp;
	logic [23:0] mant;
	logic        is_zero;
	logic        is_inf;
	logic        is_nan;
	logic        is_rsv;

	modport src (output sign, exp, mant, is_zero, is_inf, is_nan, is_rsv);
	modport dst (input sign, exp, mant, is_zero, is_inf, is_nan, is_rsv);
endinterface : fp_operand_if

// >>> design/fp_unpack.sv
// Splits a 32-bit word of either float format into sign, internal exponent and mantissa
`timescale 1ns/100ps
module fp_unpack (
	input  wire logic [31:0] word,
	input  wire logic        ieee,
	fp_operand_if.src        op
);
	wire logic [7:0] bexp    = word[30:23];
	wire logic       frac_nz = |word[22:0];
	wire logic       exp_lo  = (bexp == 8'h00);
	wire logic       exp_hi  = (bexp == fp_alu_pkg::EXP_ONES);

	assign op.sign    = word[31];
	// Denormals are flushed to zero rather than carried as small values
	assign op.is_zero = exp_lo & (ieee | ~word[31]);
	assign op.is_rsv  = ~ieee & word[31] & exp_lo; // RULE22
	assign op.is_inf  = ieee & exp_hi & ~frac_nz;
	assign op.is_nan  = ieee & exp_hi & frac_nz; // RULE21
	// Alternate exponent moved down so both formats share one internal scale
	assign op.exp     = exp_lo ? 10'h000 : ieee ? {2'b00, bexp} :
		{2'b00, bexp} - 10'(fp_alu_pkg::DEC_EXP_SHIFT); // RULE20
	assign op.mant    = exp_lo ? 24'h0 : {1'b1, word[22:0]};
endmodule : fp_unpack

// >>> design/fp_pack.sv
// Packs a normalised result into the selected format and checks exponent range
`timescale 1ns/100ps
module fp_pack (
	input  wire logic        sign,
	input  wire logic [11:0] exp,
	input  wire logic [23:0] mant,
	input  wire logic        ieee,
	output logic      [31:0] word,
	output logic             ovf,
	output logic             unf
);
	wire logic [11:0] biased;
	wire logic [11:0] exp_max;

	assign biased  = ieee ? exp : exp + 12'(fp_alu_pkg::DEC_EXP_SHIFT); // RULE20
	assign exp_max = ieee ? fp_alu_pkg::IEEE_EXP_MAX : fp_alu_pkg::DEC_EXP_MAX;
	assign ovf     = $signed(biased) > $signed(exp_max); // RULE15
	assign unf     = $signed(biased) < $signed(12'h001); // RULE15

	// Overflow gives infinity or the reserved operand; underflow flushes to zero
	always_comb begin
		if (ovf) begin
			word = ieee ? {sign, fp_alu_pkg::EXP_ONES, 23'h0} : fp_alu_pkg::RSV_WORD; // RULE18
		end else if (unf) begin
			word = ieee ? {sign, 31'h0} : 32'h0; // RULE18
		end else begin
			word = {sign, biased[7:0], mant[22:0]};
		end
	end
endmodule : fp_pack

// >>> design/fp_alu_datapath.sv
// Registered single-cycle floating-point add/subtract datapath with AXI4-Lite control
// Function
// (RULE1) Each operand register loads only while its active-low load control is low.
// (RULE2) Result register loads the ALU output while its active-low load control is low.
// (RULE3) Input bypass makes both operand registers transparent.
// (RULE4) Output bypass makes the result and flag registers transparent.
// (RULE5) Second ALU port takes operand-B register, or result register when selected.
// (RULE6) Operand-A register loads from its bus, or the ALU result when selected.
// (RULE7) Result bus is driven only while the active-low drive control is low.
// (RULE8) Format select high uses IEEE encoding, low the alternate encoding.
// (RULE9) Shared-input select high feeds both operands from the first bus.
// (RULE10) Infinity mode picks affine or projective infinities, IEEE format only.
// (RULE11) Half-width mode moves low half then high half of each word.
// (RULE12) Two rounding select bits choose one of four rounding modes.
// (RULE13) Invalid flag marks an invalid operation such as infinity minus infinity.
// (RULE14) Not-a-number flag marks a NaN or reserved-operand final result.
// (RULE15) Overflow and underflow flags mark results out of the format's range.
// (RULE16) Inexact flag marks a rounded result differing from the exact one.
// (RULE17) Zero flag marks a final result equal to zero.
// (RULE18) Compute exact, round, then substitute infinity, NaN or reserved on exceptions.
// (RULE19) Three-bit operation select; add sums the ports, subtract takes B from A.
// (RULE20) Exponent bias is 127 for IEEE, 128 alternate; fraction is low 23 bits.
// (RULE21) IEEE NaN has exponent 255 and a non-zero fraction.
// (RULE22) Alternate word with sign 1 and exponent 0 is a reserved operand.
// (RULE23) Flag register captures the latest flags on every rising edge.
// (RULE24) Controller keeps port-B select low while the result register is bypassed.
// (RULE25) Controller never sets half-width and shared-input together.
// (RULE26) Code 000 adds, 001 subtracts; other codes are other operations; here other codes give the NaN or reserved word with the invalid flag.
// (RULE27) Flag outputs change on the same edge as the result output; here the flags load every edge, the result only while its load control is low.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module fp_alu_datapath #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [31:0]       first_operand_bus,
	input  wire logic [31:0]       second_operand_bus,
	output logic      [31:0]       result_bus_o,
	output logic                   result_bus_oe,
	output logic                   invalid_flag,
	output logic                   not_number_flag,
	output logic                   overflow_flag,
	output logic                   underflow_flag,
	output logic                   inexact_flag,
	output logic                   zero_flag
);
	generate
		if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
			$error("ADDR_W must lie between 4 and 32");
		end
	endgenerate

	// Control register fields
	logic [fp_alu_pkg::CTRL_BITS-1:0] ctrl_r;
	wire logic [2:0] op_select               = ctrl_r[fp_alu_pkg::CB_OP +: 3];
	wire logic       port_b_source_select    = ctrl_r[fp_alu_pkg::CB_PORTB];
	wire logic       operand_a_source_select = ctrl_r[fp_alu_pkg::CB_ASRC];
	wire logic       format_select           = ctrl_r[fp_alu_pkg::CB_FMT];
	wire logic       infinity_mode_select    = ctrl_r[fp_alu_pkg::CB_INF];
	wire logic [1:0] rounding_select         = ctrl_r[fp_alu_pkg::CB_RND +: 2];
	wire logic       input_bypass            = ctrl_r[fp_alu_pkg::CB_IBYP];
	wire logic       output_bypass           = ctrl_r[fp_alu_pkg::CB_OBYP];
	wire logic       half_width_select       = ctrl_r[fp_alu_pkg::CB_HALF];
	wire logic       shared_input_select     = ctrl_r[fp_alu_pkg::CB_SHARED];
	wire logic       result_drive_n          = ctrl_r[fp_alu_pkg::CB_DRIVE_N];
	wire logic       first_operand_load_n    = ctrl_r[fp_alu_pkg::CB_LOAD_A_N];
	wire logic       second_operand_load_n   = ctrl_r[fp_alu_pkg::CB_LOAD_B_N];
	wire logic       result_load_n           = ctrl_r[fp_alu_pkg::CB_LOAD_F_N];

	// Datapath state
	fp_alu_pkg::half_phase_t   phase_r;
	logic [15:0]               lo_a_r;
	logic [15:0]               lo_b_r;
	logic [31:0]               a_r;
	logic [31:0]               b_r;
	logic [31:0]               result_r;
	logic [fp_alu_pkg::FLG_W-1:0] flags_r;
	logic [31:0]               alu_result;
	logic [fp_alu_pkg::FLG_W-1:0] alu_flags;

	// Illegal half-width plus shared combination falls back to two buses
	wire logic shared_on = shared_input_select & ~half_width_select; // RULE25
	wire logic load_slot = ~half_width_select | (phase_r == fp_alu_pkg::PH_HIGH); // RULE11
	wire logic [31:0] b_bus_raw = shared_on ? first_operand_bus : second_operand_bus; // RULE9
	wire logic [31:0] bus_a_word = half_width_select ?
		{first_operand_bus[15:0], lo_a_r} : first_operand_bus; // RULE11
	wire logic [31:0] bus_b_word = half_width_select ?
		{b_bus_raw[15:0], lo_b_r} : b_bus_raw; // RULE11

	// Feedback gated by bypass so no combinational loop can form
	wire logic a_from_alu = operand_a_source_select & ~input_bypass;
	wire logic b_from_res = port_b_source_select & ~output_bypass; // RULE24
	wire logic [31:0] a_in = a_from_alu ? alu_result : bus_a_word; // RULE6
	wire logic [31:0] port_a = input_bypass ? a_in : a_r; // RULE3
	wire logic [31:0] b_reg_val = input_bypass ? bus_b_word : b_r; // RULE3
	wire logic [31:0] port_b = b_from_res ? result_r : b_reg_val; // RULE5
	wire logic [31:0] result_val = output_bypass ? alu_result : result_r; // RULE4
	wire logic [fp_alu_pkg::FLG_W-1:0] flags_val = output_bypass ? alu_flags : flags_r; // RULE4

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_r <= fp_alu_pkg::PH_LOW;
		end else if (!half_width_select || phase_r == fp_alu_pkg::PH_HIGH) begin
			phase_r <= fp_alu_pkg::PH_LOW;
		end else begin
			phase_r <= fp_alu_pkg::PH_HIGH; // RULE11
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lo_a_r <= 16'h0;
			lo_b_r <= 16'h0;
		end else if (phase_r == fp_alu_pkg::PH_LOW) begin
			lo_a_r <= first_operand_bus[15:0]; // RULE11
			lo_b_r <= b_bus_raw[15:0]; // RULE11
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_r <= 32'h0;
		end else if (!first_operand_load_n && load_slot) begin
			a_r <= a_in; // RULE1
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			b_r <= 32'h0;
		end else if (!second_operand_load_n && load_slot) begin
			b_r <= bus_b_word; // RULE1
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_r <= 32'h0;
		end else if (!result_load_n) begin
			result_r <= alu_result; // RULE2
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= '0;
		end else begin
			flags_r <= alu_flags; // RULE23
		end
	end

	// Half-width output shows the low half in the first slot, high half in the second
	assign result_bus_o = !half_width_select ? result_val :
		{16'h0, (phase_r == fp_alu_pkg::PH_LOW) ? result_val[15:0] : result_val[31:16]}; // RULE11
	assign result_bus_oe   = ~result_drive_n; // RULE7
	assign invalid_flag    = flags_val[fp_alu_pkg::FLG_INVALID]; // RULE27
	assign not_number_flag = flags_val[fp_alu_pkg::FLG_NAN]; // RULE27
	assign overflow_flag   = flags_val[fp_alu_pkg::FLG_OVF]; // RULE27
	assign underflow_flag  = flags_val[fp_alu_pkg::FLG_UNF]; // RULE27
	assign inexact_flag    = flags_val[fp_alu_pkg::FLG_INEXACT]; // RULE27
	assign zero_flag       = flags_val[fp_alu_pkg::FLG_ZERO]; // RULE27

	// Operand decode
	fp_operand_if ua ();
	fp_operand_if ub ();
	wire logic fmt_ieee = format_select; // RULE8

	fp_unpack u_unpack_a (
		.word (port_a),
		.ieee (fmt_ieee),
		.op   (ua)
	);

	fp_unpack u_unpack_b (
		.word (port_b),
		.ieee (fmt_ieee),
		.op   (ub)
	);

	function automatic logic [4:0] lead_zeros(input logic [27:0] v);
		logic [4:0] n;
		logic       found;
		n = 5'h0;
		found = 1'b0;
		for (int i = 27; i >= 0; i--) begin
			if (v[i]) begin
				found = 1'b1;
			end else if (!found) begin
				n = n + 5'h1;
			end
		end
		return n;
	endfunction : lead_zeros

	// Exact sum, with guard, round and sticky bits kept below the mantissa
	wire logic op_ok   = (op_select == fp_alu_pkg::OP_ADD) || (op_select == fp_alu_pkg::OP_SUB); // RULE26
	wire logic sb_eff  = ub.sign ^ (op_select == fp_alu_pkg::OP_SUB); // RULE19
	wire logic a_ge    = ($signed(ua.exp) > $signed(ub.exp)) ||
		((ua.exp == ub.exp) && (ua.mant >= ub.mant));
	wire logic        l_sign = a_ge ? ua.sign : sb_eff;
	wire logic        s_sign = a_ge ? sb_eff : ua.sign;
	wire logic [9:0]  l_exp  = a_ge ? ua.exp : ub.exp;
	wire logic [9:0]  s_exp  = a_ge ? ub.exp : ua.exp;
	wire logic [23:0] l_mant = a_ge ? ua.mant : ub.mant;
	wire logic [23:0] s_mant = a_ge ? ub.mant : ua.mant;
	wire logic [9:0]  diff   = l_exp - s_exp;
	wire logic [4:0]  dsh    = (diff > 10'd27) ? 5'd27 : diff[4:0];
	wire logic [53:0] wide   = {s_mant, 3'b000, 27'h0} >> dsh;
	wire logic [26:0] al     = {wide[53:28], wide[27] | (|wide[26:0])};
	wire logic        eff_sub = l_sign ^ s_sign;
	wire logic [27:0] sum28  = eff_sub ? ({1'b0, l_mant, 3'b000} - {1'b0, al}) :
		({1'b0, l_mant, 3'b000} + {1'b0, al}); // RULE19
	wire logic        sum_zero = (sum28 == 28'h0);
	wire logic [4:0]  lz     = lead_zeros(sum28);
	wire logic [27:0] shl    = sum28 << (lz - 5'h1);
	wire logic [26:0] n27    = (lz == 5'h0) ? {sum28[27:2], sum28[1] | sum28[0]} : shl[26:0];
	wire logic [11:0] n_exp  = {{2{l_exp[9]}}, l_exp} + 12'h001 - {7'h0, lz};

	// Rounding to 24 significant bits
	wire logic        rnd_inexact = |n27[2:0]; // RULE16
	logic             rnd_inc;
	always_comb begin
		unique case (rounding_select) // RULE12
			fp_alu_pkg::RND_NEAREST: rnd_inc = n27[2] & (n27[1] | n27[0] | n27[3]);
			fp_alu_pkg::RND_PLUS:    rnd_inc = rnd_inexact & ~l_sign;
			fp_alu_pkg::RND_MINUS:   rnd_inc = rnd_inexact & l_sign;
			fp_alu_pkg::RND_ZERO:    rnd_inc = 1'b0;
		endcase
	end
	wire logic [24:0] m25   = {1'b0, n27[26:3]} + {24'h0, rnd_inc};
	wire logic [23:0] r_mant = m25[24] ? m25[24:1] : m25[23:0];
	wire logic [11:0] r_exp  = n_exp + {11'h0, m25[24]};

	logic [31:0] pk_word;
	logic        pk_ovf;
	logic        pk_unf;

	fp_pack u_pack (
		.sign (l_sign),
		.exp  (r_exp),
		.mant (r_mant),
		.ieee (fmt_ieee),
		.word (pk_word),
		.ovf  (pk_ovf),
		.unf  (pk_unf)
	);

	wire logic        zero_sign = eff_sub ? (rounding_select == fp_alu_pkg::RND_MINUS) : l_sign;
	wire logic [31:0] zero_word = fmt_ieee ? {zero_sign, 31'h0} : 32'h0;
	wire logic [31:0] nan_word  = fmt_ieee ? fp_alu_pkg::QNAN_WORD : fp_alu_pkg::RSV_WORD;
	wire logic        any_nan   = fmt_ieee & (ua.is_nan | ub.is_nan);
	wire logic        any_rsv   = ~fmt_ieee & (ua.is_rsv | ub.is_rsv);
	wire logic        both_inf  = fmt_ieee & ua.is_inf & ub.is_inf;
	wire logic        inf_clash = infinity_mode_select | (ua.sign ^ sb_eff); // RULE10

	// Exception stage overrides the rounded result
	always_comb begin
		alu_result = pk_word;
		alu_flags = '0;
		alu_flags[fp_alu_pkg::FLG_OVF] = pk_ovf; // RULE15
		alu_flags[fp_alu_pkg::FLG_UNF] = pk_unf; // RULE15
		alu_flags[fp_alu_pkg::FLG_INEXACT] = rnd_inexact | pk_ovf | pk_unf; // RULE16
		if (!op_ok) begin
			alu_result = nan_word;
			alu_flags = '0;
			alu_flags[fp_alu_pkg::FLG_INVALID] = 1'b1; // RULE13
		end else if (any_nan) begin
			alu_result = fp_alu_pkg::QNAN_WORD; // RULE18
			alu_flags = '0;
		end else if (any_rsv) begin
			alu_result = fp_alu_pkg::RSV_WORD; // RULE22
			alu_flags = '0;
			alu_flags[fp_alu_pkg::FLG_INVALID] = 1'b1; // RULE13
		end else if (both_inf) begin
			alu_flags = '0;
			alu_result = {ua.sign, fp_alu_pkg::EXP_ONES, 23'h0};
			if (inf_clash) begin
				alu_result = fp_alu_pkg::QNAN_WORD; // RULE18
				alu_flags[fp_alu_pkg::FLG_INVALID] = 1'b1; // RULE13
			end
		end else if (fmt_ieee && ua.is_inf) begin
			alu_result = {ua.sign, fp_alu_pkg::EXP_ONES, 23'h0};
			alu_flags = '0;
		end else if (fmt_ieee && ub.is_inf) begin
			alu_result = {sb_eff, fp_alu_pkg::EXP_ONES, 23'h0};
			alu_flags = '0;
		end else if (sum_zero) begin
			alu_result = zero_word;
			alu_flags = '0;
		end
		alu_flags[fp_alu_pkg::FLG_NAN] = fmt_ieee ?
			((alu_result[30:23] == fp_alu_pkg::EXP_ONES) && (alu_result[22:0] != 23'h0)) :
			(alu_result[31] && (alu_result[30:23] == 8'h00)); // RULE14 RULE21
		alu_flags[fp_alu_pkg::FLG_ZERO] = fmt_ieee ? (alu_result[30:0] == 31'h0) :
			(alu_result == 32'h0); // RULE17
	end

	// AXI4-Lite slave: address and data taken independently, one write and one read in flight
	logic              aw_hold_r;
	logic              w_hold_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic [31:0]       ctrl_nxt;

	wire logic [7:0] wr_off  = 8'(awaddr_r);
	wire logic [7:0] rd_off  = 8'(s_axi_araddr);
	wire logic do_write = aw_hold_r & w_hold_r & ~bvalid_r;
	wire logic wr_ctrl  = (wr_off == fp_alu_pkg::CTRL_OFF);
	wire logic wr_known = wr_ctrl || (wr_off == fp_alu_pkg::STATUS_OFF) ||
		(wr_off == fp_alu_pkg::RESULT_OFF);
	wire logic rd_take  = s_axi_arvalid & ~rvalid_r;
	wire logic rd_ctrl  = (rd_off == fp_alu_pkg::CTRL_OFF);
	wire logic rd_stat  = (rd_off == fp_alu_pkg::STATUS_OFF);
	wire logic rd_res   = (rd_off == fp_alu_pkg::RESULT_OFF);
	wire logic [31:0] rd_mux = rd_ctrl ? {15'h0, ctrl_r} :
		rd_stat ? {26'h0, flags_val} : rd_res ? result_val : 32'h0;
	wire logic [31:0] ctrl_wide = {15'h0, ctrl_r};

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_strb
			assign ctrl_nxt[gb*8 +: 8] = wstrb_r[gb] ? wdata_r[gb*8 +: 8] : ctrl_wide[gb*8 +: 8];
		end
	endgenerate

	assign s_axi_awready = ~aw_hold_r;
	assign s_axi_wready  = ~w_hold_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (s_axi_awvalid && !aw_hold_r) begin
			aw_hold_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (do_write) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_r <= 1'b0;
			wdata_r  <= 32'h0;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && !w_hold_r) begin
			w_hold_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (do_write) begin
			w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= fp_alu_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_known ? fp_alu_pkg::RESP_OKAY : fp_alu_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= fp_alu_pkg::CTRL_RESET[fp_alu_pkg::CTRL_BITS-1:0];
		end else if (do_write && wr_ctrl) begin
			ctrl_r <= ctrl_nxt[fp_alu_pkg::CTRL_BITS-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= fp_alu_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= (rd_ctrl || rd_stat || rd_res) ? fp_alu_pkg::RESP_OKAY :
				fp_alu_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule : fp_alu_datapath

// >>> tb/fp_alu_properties.sv
// Port-level checks on the floating-point datapath
`timescale 1ns/100ps
module fp_alu_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic result_bus_oe,
	input wire logic invalid_flag,
	input wire logic not_number_flag,
	input wire logic overflow_flag,
	input wire logic zero_flag
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_oe_after_reset: assert property ($rose(aresetn) |-> !result_bus_oe)
		else $error("result bus driven after reset");
	a_zero_at_start: assert property ($rose(aresetn) |-> ##[1:2] zero_flag)
		else $error("zero flag missing for cleared operands");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	a_write_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second write address taken too early");
	a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_invalid_gives_nan: assert property (invalid_flag |-> not_number_flag)
		else $error("invalid operation without symbolic result");
	a_zero_not_symbol: assert property (zero_flag |-> !not_number_flag && !overflow_flag)
		else $error("zero flag with symbol or overflow");
	cover property (invalid_flag);
	cover property (overflow_flag);
	cover property (s_axi_awvalid && s_axi_awready);
endmodule : fp_alu_properties

// >>> tb/fp_alu_host.sv
// Host controller model: AXI4-Lite master programming the datapath
`timescale 1ns/100ps
module fp_alu_host (
	input  wire logic        aclk,
	output logic      [7:0]  s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic      [3:0]  s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [7:0]  s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
	end
	// Timeout answers 3, a code the slave never gives, so the bench flags it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		r = 2'h3;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'h3;
		d = 32'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (int n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				{d, r} = {s_axi_rdata, s_axi_rresp};
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rd
endmodule : fp_alu_host

// >>> tb/fp_alu_datapath_test.sv
// Self-checking bench for the floating-point datapath
`timescale 1ns/100ps
module fp_alu_datapath_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, first_operand_bus, second_operand_bus, result_bus_o, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic result_bus_oe, invalid_flag, not_number_flag, overflow_flag;
	logic underflow_flag, inexact_flag, zero_flag;
	int n_mismatch, checks;
	fp_alu_datapath i_fp_alu_datapath (.*);
	fp_alu_host i_fp_alu_host (.*);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wrap_up;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// Control written first, so the old operands load while it lands
	task run(input logic [31:0] a, input logic [31:0] b, input logic [31:0] ctl);
		i_fp_alu_host.wr(fp_alu_pkg::CTRL_OFF, ctl, r);
		chk(32'(r), 32'(fp_alu_pkg::RESP_OKAY));
		first_operand_bus <= a;
		second_operand_bus <= b;
		repeat (3) @(posedge aclk);
		#1;
	endtask : run
	task t_regs;
		i_fp_alu_host.rd(fp_alu_pkg::CTRL_OFF, d, r);
		chk(d, fp_alu_pkg::CTRL_RESET);
		chk(32'(r), 32'(fp_alu_pkg::RESP_OKAY));
		chk(32'(result_bus_oe), 32'h0);
		i_fp_alu_host.rd(8'h0c, d, r);
		chk({d[29:0], r}, 32'(fp_alu_pkg::RESP_SLVERR));
		i_fp_alu_host.wr(fp_alu_pkg::STATUS_OFF, 32'hffffffff, r);
		chk(32'(r), 32'(fp_alu_pkg::RESP_OKAY));
		i_fp_alu_host.rd(fp_alu_pkg::STATUS_OFF, d, r);
		chk(d, 32'h20);
		chk(32'(r), 32'(fp_alu_pkg::RESP_OKAY));
		$display("t_regs done");
	endtask : t_regs
	task t_arith;
		run(32'h3f800000, 32'h40000000, 32'h20);
		chk(result_bus_o, 32'h40400000);
		chk(32'(result_bus_oe), 32'h1);
		run(32'h3f800000, 32'h40000000, 32'h21);
		chk(result_bus_o, 32'hbf800000);
		run(32'h3f800000, 32'h3f800000, 32'h21);
		chk(32'({zero_flag, not_number_flag}), 32'h2);
		run(32'h40000000, 32'h40000000, 32'h4020);
		chk(result_bus_o, 32'h40400000);
		run(32'h40800000, 32'h40800000, 32'h10020);
		chk(result_bus_o, 32'h40400000);
		$display("t_arith done");
	endtask : t_arith
	task t_bypass;
		// Port-B select and shared-input kept low here
		run(32'h3f800000, 32'h3f800000, 32'h1c620);
		chk(result_bus_o, 32'h40000000);
		$display("t_bypass done");
	endtask : t_bypass
	task t_except;
		run(32'h7f7fffff, 32'h7f7fffff, 32'h20);
		chk(result_bus_o, 32'h7f800000);
		chk(32'({overflow_flag, inexact_flag}), 32'h3);
		run(32'h00800000, 32'h00c00000, 32'h21);
		chk(result_bus_o, 32'h80000000);
		chk(32'({underflow_flag, inexact_flag}), 32'h3);
		run(32'h3f800000, 32'h3f800000, 32'h22);
		chk(result_bus_o, fp_alu_pkg::QNAN_WORD);
		chk(32'({invalid_flag, not_number_flag}), 32'h3);
		run(32'h40800000, 32'h40800000, 32'h00);
		chk(result_bus_o, 32'h41000000);
		run(32'h40800000, 32'h40800000, 32'h02);
		chk(result_bus_o, fp_alu_pkg::RSV_WORD);
		$display("t_except done");
	endtask : t_except
	initial begin
		{aresetn, first_operand_bus, second_operand_bus} = 65'h0;
		{n_mismatch, checks} = 64'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_arith;
		t_bypass;
		t_except;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		wrap_up;
	end
endmodule : fp_alu_datapath_test
bind fp_alu_datapath fp_alu_properties i_fp_alu_properties (.*);
